//--- dacr_top.sv
// Purpose: conversion control and serial readout, dual 16-bit converter
// Assumes: host drives chip select and serial clock; both are pins
// Notes:   core codes arrive offset binary on ref_clk
`timescale 1ns/1ps
`default_nettype none

module dacr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             inVld,
    output logic                  inRdy,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outVld,
    input  wire logic             outRdy,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic             doPush;
    logic             doPop;

    assign inRdy   = (count_ff != (AW+1)'(DEPTH));
    assign outVld  = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign doPush  = inVld && inRdy;
    assign doPop   = outVld && outRdy;

    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doPush) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doPop) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

module dacr_top #(
    parameter int FIFO_DEPTH = dacr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        arst_n,
    // host pins
    input  wire logic                        csN,
    input  wire logic                        sclk,
    input  wire logic                        powerDown,
    // converter core codes, offset binary
    input  wire logic [dacr_pkg::RES_W-1:0]  codeA,
    input  wire logic [dacr_pkg::RES_W-1:0]  codeB,
    // serial data pins, enable low while driven
    output logic                             chanAUpperDataOut,
    output logic                             chanALowerDataOut,
    output logic                             chanBUpperDataOut,
    output logic                             chanBLowerDataOut,
    output logic                             dataOeN,
    // status
    output logic                             acquirePhase,
    output logic                             convertPhase,
    output logic                             conversionDoneInternal
);
    // pin synchronisers: stage 1 read only by stage 2
    logic [1:0] csMeta_ff;
    logic [1:0] sclkMeta_ff;
    logic [1:0] pdMeta_ff;
    logic       csSync_ff;
    logic       csPrev_ff;
    logic       sclkPrev_ff;
    logic       csRise;
    logic       csFall;
    logic       sclkRise;
    logic       pdSync;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            csMeta_ff   <= 2'h3;
            sclkMeta_ff <= 2'h0;
            pdMeta_ff   <= 2'h0;
            csPrev_ff   <= 1'b1;
            sclkPrev_ff <= 1'b0;
        end else begin
            csMeta_ff   <= {csMeta_ff[0], csN};
            sclkMeta_ff <= {sclkMeta_ff[0], sclk};
            pdMeta_ff   <= {pdMeta_ff[0], powerDown};
            csPrev_ff   <= csMeta_ff[1];
            sclkPrev_ff <= sclkMeta_ff[1];
        end
    end

    assign csSync_ff = csMeta_ff[1];
    assign pdSync    = pdMeta_ff[1];
    assign csRise    = csSync_ff && !csPrev_ff;
    assign csFall    = !csSync_ff && csPrev_ff;
    assign sclkRise  = sclkMeta_ff[1] && !sclkPrev_ff && !csSync_ff;

    // conversion sequencer, timed by ref_clk only
    dacr_pkg::dacr_phase_t         phase_ff;
    logic [dacr_pkg::CONV_CNT_W-1:0] convCnt_ff;
    logic [dacr_pkg::RES_W-1:0]    heldA_ff;
    logic [dacr_pkg::RES_W-1:0]    heldB_ff;
    logic                          fifoInRdy;
    logic                          fifoOutVld;
    logic                          push;
    logic                          startConv;
    dacr_pkg::dacr_result_t        fifoIn;
    dacr_pkg::dacr_result_t        fifoOut;

    assign startConv = csRise && (phase_ff == dacr_pkg::PH_ACQUIRE)
                       && !pdSync;
    // a full buffer stalls completion rather than dropping a result
    assign push = (phase_ff == dacr_pkg::PH_CONVERT) && (convCnt_ff == '0)
                  && fifoInRdy && !pdSync;
    // flip the sign bit: offset binary to two's complement
    assign fifoIn.chanA = {~heldA_ff[15], heldA_ff[14:0]};
    assign fifoIn.chanB = {~heldB_ff[15], heldB_ff[14:0]};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff   <= dacr_pkg::PH_ACQUIRE;
            convCnt_ff <= '0;
            heldA_ff   <= dacr_pkg::RESULT_RST;
            heldB_ff   <= dacr_pkg::RESULT_RST;
        end else begin
            case (phase_ff)
                dacr_pkg::PH_ACQUIRE: begin
                    if (startConv) begin
                        phase_ff   <= dacr_pkg::PH_CONVERT;
                        convCnt_ff <= dacr_pkg::CONV_CNT_W'(
                                      dacr_pkg::CONV_CYCLES - 1);
                        heldA_ff   <= codeA;
                        heldB_ff   <= codeB;
                    end
                end
                dacr_pkg::PH_CONVERT: begin
                    if (pdSync || push) begin
                        phase_ff <= dacr_pkg::PH_ACQUIRE;
                    end else if (convCnt_ff != '0) begin
                        convCnt_ff <= convCnt_ff - 1'b1;
                    end
                end
                default: phase_ff <= dacr_pkg::PH_ACQUIRE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acquirePhase           <= 1'b1;
            convertPhase           <= 1'b0;
            conversionDoneInternal <= 1'b0;
        end else begin
            acquirePhase <= !startConv && (phase_ff == dacr_pkg::PH_ACQUIRE
                            || push || pdSync);
            convertPhase <= startConv || (phase_ff == dacr_pkg::PH_CONVERT
                            && !push && !pdSync);
            conversionDoneInternal <= push;
        end
    end

    // readout side drains only between frames, so in-frame results wait
    logic                   inFrame_ff;
    dacr_pkg::dacr_result_t latest_ff;

    dacr_fifo #(
        .WIDTH (2*dacr_pkg::RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .inVld   (push),
        .inRdy   (fifoInRdy),
        .inData  (fifoIn),
        .outVld  (fifoOutVld),
        .outRdy  (!inFrame_ff),
        .outData (fifoOut)
    );

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            latest_ff <= '0;
        end else if (fifoOutVld && !inFrame_ff) begin
            latest_ff <= fifoOut;
        end
    end

    // shift registers: bits [15:14] of each are the pin values
    logic [dacr_pkg::RES_W-1:0]      shA_ff;
    logic [dacr_pkg::RES_W-1:0]      shB_ff;
    logic [dacr_pkg::PAIR_CNT_W-1:0] pairCnt_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            inFrame_ff <= 1'b0;
            shA_ff     <= '0;
            shB_ff     <= '0;
            pairCnt_ff <= '0;
            dataOeN    <= 1'b1;
        end else if (csRise) begin
            inFrame_ff <= 1'b0;
            dataOeN    <= 1'b1;
        end else if (csFall) begin
            inFrame_ff <= 1'b1;
            dataOeN    <= 1'b0;
            shA_ff     <= latest_ff.chanA;
            shB_ff     <= latest_ff.chanB;
            pairCnt_ff <= 4'h1;
        end else if (sclkRise && inFrame_ff) begin
            // zeros fill in behind the last pair
            shA_ff <= {shA_ff[13:0], 2'b00};
            shB_ff <= {shB_ff[13:0], 2'b00};
            if (pairCnt_ff != 4'h9) begin
                pairCnt_ff <= pairCnt_ff + 1'b1;
            end
        end
    end

    assign chanAUpperDataOut = shA_ff[15];
    assign chanALowerDataOut = shA_ff[14];
    assign chanBUpperDataOut = shB_ff[15];
    assign chanBLowerDataOut = shB_ff[14];

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_start;
        startConv;
    endsequence
    sequence s_convRun;
        (phase_ff == dacr_pkg::PH_CONVERT)[*4];
    endsequence

    property p_start;
        s_start |=> s_convRun;
    endproperty
    a_start: assert property (p_start)
        else $error("conversion did not start on chip select rise");

    property p_doneAcq;
        conversionDoneInternal |-> acquirePhase && !convertPhase;
    endproperty
    a_doneAcq: assert property (p_doneAcq)
        else $error("not in acquire after conversion done");

    property p_convCount;
        phase_ff == dacr_pkg::PH_CONVERT && convCnt_ff != '0 && !pdSync
        |=> convCnt_ff == $past(convCnt_ff) - 1'b1;
    endproperty
    a_convCount: assert property (p_convCount)
        else $error("conversion count not driven by internal clock");

    // a full buffer is the only legal stall, so it excuses the bound
    localparam int CONV_LIMIT = dacr_pkg::CONV_CYCLES + 1;

    property p_convTime;
        s_start |-> ##[1:CONV_LIMIT]
            (phase_ff == dacr_pkg::PH_ACQUIRE || !fifoInRdy);
    endproperty
    a_convTime: assert property (p_convTime)
        else $error("conversion exceeded its time budget");

    property p_load;
        csFall |=> chanAUpperDataOut == $past(latest_ff.chanA[15])
               && chanALowerDataOut == $past(latest_ff.chanA[14])
               && chanBUpperDataOut == $past(latest_ff.chanB[15])
               && !dataOeN;
    endproperty
    a_load: assert property (p_load)
        else $error("first bit pair wrong at frame start");

    property p_shift;
        sclkRise && inFrame_ff && !csRise
        |=> shA_ff == {$past(shA_ff[13:0]), 2'b00};
    endproperty
    a_shift: assert property (p_shift)
        else $error("bit pair not advanced on serial clock rise");

    property p_zero;
        inFrame_ff && pairCnt_ff == 4'h9
        |-> shA_ff == '0 && shB_ff == '0;
    endproperty
    a_zero: assert property (p_zero)
        else $error("data lines not zero after last pair");

    property p_end;
        csRise |=> dataOeN && !inFrame_ff;
    endproperty
    a_end: assert property (p_end)
        else $error("frame did not end on chip select rise");

    property p_twos;
        push |=> ##1 latest_ff.chanA == $past(fifoIn.chanA, 2)
                 || $past(inFrame_ff) || $past(fifoOutVld, 2);
    endproperty
    a_twos: assert property (p_twos)
        else $error("result word not passed in two's complement");
endmodule

`default_nettype wire

//--- dacr_pkg.sv
// Purpose: shared constants and types for the dual-channel readout block
// Assumes: ref_clk at 100 MHz
// Notes:   conversion count derived from times in ns; SYNC_LAT given in cycles
package dacr_pkg;
    localparam int RES_W         = 16;
    localparam int PAIRS         = RES_W / 2;
    localparam int PAIR_CNT_W    = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_MAX_NS   = 422;
    // pin synchroniser and edge detect delay the start of conversion
    localparam int SYNC_LAT      = 3;
    // longest time rounds down; sync latency taken out of the budget
    localparam int CONV_CYCLES   = CONV_MAX_NS / CLK_PERIOD_NS - SYNC_LAT;
    localparam int CONV_CNT_W    = 6;
    localparam int FIFO_DEPTH    = 4;
    localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

    typedef enum logic {PH_ACQUIRE, PH_CONVERT} dacr_phase_t;

    typedef struct packed {
        logic [RES_W-1:0] chanA;
        logic [RES_W-1:0] chanB;
    } dacr_result_t;
endpackage

//--- dacr_host.sv
// Purpose: host model, drives chip select and serial clock
// Assumes: ref_clk paces the model; h is the clock half period, h >= 8
// Notes:   pairs sampled six cycles after chip select fall or serial clock rise, well after the launch edge
`timescale 1ns/1ps
`default_nettype none
module dacr_host (
    // clock
    input  wire logic       ref_clk,
    // host pins
    output var logic        csN,
    output var logic        sclk,
    // data pins, a upper, a lower, b upper, b lower
    input  wire logic [3:0] sdo,
    input  wire logic       dataOeN
);
    logic [15:0] rxA;
    logic [15:0] rxB;
    logic        tailZero;
    logic        oeOk;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
    end
    // caller spaces rises by a whole frame or conversion
    task automatic rise();
        @(posedge ref_clk);
        csN <= 1'b1;
    endtask
    task automatic frame(input int h);
        int k;
        @(posedge ref_clk);
        csN <= 1'b0;
        repeat (6) @(posedge ref_clk);
        oeOk = 1'b1;
        for (k = 0; k < 9; k++) begin
            if (k > 0) begin
                @(posedge ref_clk);
                // off the clock edge: the link clock is not in phase
                sclk <= #3 1'b1;
                repeat (6) @(posedge ref_clk);
            end
            @(negedge ref_clk);
            if (dataOeN !== 1'b0) oeOk = 1'b0;
            if (k < 8) begin
                rxA = {rxA[13:0], sdo[3:2]};
                rxB = {rxB[13:0], sdo[1:0]};
            end else begin
                tailZero = (sdo === 4'h0);
            end
            if (k > 0) begin
                repeat (h - 6) @(posedge ref_clk);
                sclk <= #3 1'b0;
                repeat (h - 1) @(posedge ref_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

//--- test_dacr_top.sv
// Purpose: self-checking bench for the dual readout block
// Assumes: host model drives chip select and serial clock
// Notes:   expected words worked out from the codes driven
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin \
    failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_dacr_top;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        powerDown = 1'b0;
    logic [31:0] codes = 32'h0000_0000;
    logic        aUp, aLo, bUp, bLo, oeN, acqPh, cnvPh, done, csN, sclk;
    logic [31:0] lastWord = {2{dacr_pkg::RESULT_RST}};
    logic [31:0] newWord;
    logic [31:0] edgeCodes [4] = '{32'h0000_ffff, 32'h8000_7fff,
                                   32'h7fff_8000, 32'hffff_0000};
    int          failures = 0, numChecks = 0, cyc = 0, startCyc = 0;
    int          doneCnt = 0, lastLat = 0, i;

    dacr_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .csN(csN),
        .sclk(sclk), .powerDown(powerDown), .codeA(codes[31:16]),
        .codeB(codes[15:0]), .chanAUpperDataOut(aUp),
        .chanALowerDataOut(aLo), .chanBUpperDataOut(bUp),
        .chanBLowerDataOut(bLo), .dataOeN(oeN), .acquirePhase(acqPh),
        .convertPhase(cnvPh), .conversionDoneInternal(done));
    dacr_host host (.ref_clk(ref_clk), .csN(csN), .sclk(sclk),
        .sdo({aUp, aLo, bUp, bLo}), .dataOeN(oeN));

    always #5 ref_clk = ~ref_clk;
    // counted at the falling edge so the tasks never race it
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            doneCnt++;
            lastLat = cyc - startCyc;
        end
        cyc++;
    end

    task automatic stop_test();
        if (failures == 0 && numChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic run_cycle(input bit lat1, input int h);
        logic [31:0] prev;
        int          n0;
        prev = lastWord;
        n0 = doneCnt;
        newWord = codes ^ 32'h8000_8000;
        host.rise();
        startCyc = cyc;
        repeat (6) @(negedge ref_clk);
        `CHK("phase", 2'h1, {acqPh, cnvPh})
        if (!lat1) begin
            repeat (45) @(negedge ref_clk);
            `CHK("idle", 3'h5, {acqPh, cnvPh, oeN})
            prev = newWord;
        end
        host.frame(h);
        `CHK("word", prev, {host.rxA, host.rxB})
        `CHK("tail", 2'h3, {host.tailZero, host.oeOk})
        `CHK("done", n0 + 1, doneCnt)
        // one cycle of slack for where the pin edge falls
        `CHK("conv time", 1, lastLat <= 43)
        lastWord = newWord;
    endtask

    task automatic abort_conv();
        int n0;
        n0 = doneCnt;
        host.rise();
        repeat (10) @(posedge ref_clk);
        powerDown <= 1'b1;
        repeat (50) @(negedge ref_clk);
        `CHK("abort", 3'h4, {acqPh, cnvPh, done})
        `CHK("no result", n0, doneCnt)
        @(posedge ref_clk);
        powerDown <= 1'b0;
        host.frame(8);
        `CHK("word", lastWord, {host.rxA, host.rxB})
    endtask

    // results drain between frames, so the buffer must end up empty
    task automatic burst_test();
        int n0;
        n0 = doneCnt;
        repeat (4) begin
            @(posedge ref_clk);
            codes <= $urandom;
            @(posedge ref_clk);
            lastWord = codes ^ 32'h8000_8000;
            host.rise();
            repeat (50) @(posedge ref_clk);
            host.frame(8);
            `CHK("burst data", lastWord, {host.rxA, host.rxB})
        end
        `CHK("burst count", n0 + 4, doneCnt)
        `CHK("fifo drain", 3'h0, dut.u_fifo.count_ff)
        `CHK("fifo empty", 1'b0, dut.fifoOutVld)
    endtask

    // a full run takes some 3,000 cycles
    initial begin
        #400_000;
        failures++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hb385));
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        `CHK("reset", 4'ha, {acqPh, cnvPh, oeN, done})
        host.frame(8);
        `CHK("word", lastWord, {host.rxA, host.rxB})
        for (i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            codes <= (i < 4) ? edgeCodes[i] : $urandom;
            @(posedge ref_clk);
            run_cycle(i[0], (i == 5) ? 12 : 8);
        end
        abort_conv();
        run_cycle(1'b1, 8);
        burst_test();
        stop_test();
    end
endmodule
`default_nettype wire
